// [hbcp_defs.svh]
// Constants of the H-bridge chopper and protection timing block
// What this block does
// - Forward: charge first-high/second-low, brake both lows, recovery first-low/second-high.
// - Reverse: charge first-low/second-high, brake both lows, recovery first-high/second-low.
// - Fault inputs are ignored for three oscillator clocks after blanking starts.
// - Detected fault syncs to oscillator, bridge off one clock later, four total.
// - Digital blanking is four oscillator clocks with select low, six with high.
// - Digital blanking restarts at each chopping period end while driving and at each phase input change.
// - Trip comparator is suppressed while digital blanking runs in charge.
// - A fixed 400 ns analog blanking also suppresses the trip comparator.
// - Chopping period is sixteen oscillator clocks.
// - After trip, decay is fast then slow, switching at 37.5 percent of period.
// - Trip after the mixed decay point keeps fast decay for the rest of period.
// - A latched fault keeps all bridge outputs off until reset.
`ifndef HBCP_DEFS_SVH
`define HBCP_DEFS_SVH
`define HBCP_OFF_CTRL 4'h0
`define HBCP_OFF_STATUS 4'h4
`define HBCP_OFF_MASK 4'h8
`define HBCP_OFF_STATE 4'hC
`define HBCP_CTRL_RST 1'b1
`define HBCP_ST_OVC 0
`define HBCP_ST_SOV 1
`define HBCP_ST_TRIP 2
`define HBCP_OSC_DIV 6
`define HBCP_CHOP_TICKS 16
`define HBCP_MDT_TICKS 6
`define HBCP_FBLK_TICKS 3
`define HBCP_DBLK_LO 4
`define HBCP_DBLK_HI 6
`define HBCP_CLK_NS 100
`define HBCP_ABLK_NS 400
`define HBCP_ABLK_CYC ((`HBCP_ABLK_NS + `HBCP_CLK_NS - 1) / `HBCP_CLK_NS)
`endif

// [hbcp_pkg.sv]
// Types of the H-bridge chopper and protection timing block
package hbcp_pkg;
  typedef enum logic [4:0] {
    HBCP_IDLE = 5'b0_0001,
    HBCP_CHARGE = 5'b0_0010,
    HBCP_FAST = 5'b0_0100,
    HBCP_SLOW = 5'b0_1000,
    HBCP_HALT = 5'b1_0000
  } hbcp_state_t;
endpackage

// [hbcp_bridge.sv]
// One H-bridge chopper with fault timing and Avalon-MM registers
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "hbcp_defs.svh"
module hbcp_bridge #(
  parameter int OSC_DIV = `HBCP_OSC_DIV
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // Controller pins
  input wire logic PHASE_A_IN,
  input wire logic PHASE_B_IN,
  input wire logic BLANK_SELECT_BRIDGE_A_IN,
  // Analog sensing
  input wire logic TRIP_CMP_IN,
  input wire logic OVER_CURRENT_FAULT_IN,
  input wire logic SENSE_OVERVOLTAGE_FAULT_IN,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Gates and interrupt
  output logic FIRST_HIGH_SIDE_OUT,
  output logic FIRST_LOW_SIDE_OUT,
  output logic SECOND_HIGH_SIDE_OUT,
  output logic SECOND_LOW_SIDE_OUT,
  output logic IRQ_OUT
);
  localparam int ACW = $clog2(OSC_DIV);

  // Refuse a divider too short to make a tick
  if (OSC_DIV < 2) begin : g_div_check
    $error("OSC_DIV must be at least 2");
  end

  // Pin synchronisers, two stages each
  logic [5:0] sync1_q, sync2_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {PHASE_A_IN, PHASE_B_IN, BLANK_SELECT_BRIDGE_A_IN, TRIP_CMP_IN,
                  OVER_CURRENT_FAULT_IN, SENSE_OVERVOLTAGE_FAULT_IN};
      sync2_q <= sync1_q;
    end
  end
  logic ph_a, ph_b, blk_sel, trip_s, ovc_s, sov_s;
  assign {ph_a, ph_b, blk_sel, trip_s, ovc_s, sov_s} = sync2_q;

  // Register state
  logic ctrl_en_q, ctrl_en_d;
  logic [2:0] status_q, status_d, mask_q, mask_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  // Core state
  hbcp_pkg::hbcp_state_t st_q, st_d;
  logic [ACW-1:0] div_q, div_d;
  logic [3:0] chop_q, chop_d;
  logic [2:0] dblk_q, dblk_d;
  logic [2:0] ablk_q, ablk_d;
  logic [1:0] fblk_q, fblk_d;
  logic [1:0] phase_q, phase_d;
  logic pend_q, pend_d;
  logic [1:0] fsrc_q, fsrc_d;
  logic halt_q, halt_d;
  logic [3:0] gate_q, gate_d;
  logic tick, restart, drive, fwd, trip_ok, fault_in, halt_rise;
  logic [3:0] target;

  // Avalon slave: one wait cycle, then answer
  always_comb begin
    ack_d = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
    rdata_d = rdata_q;
    ctrl_en_d = ctrl_en_q;
    mask_d = mask_q;
    status_d = status_q;
    if (AVS_READ_IN && !ack_q) begin
      if (AVS_ADDRESS_IN == `HBCP_OFF_CTRL) begin
        rdata_d = {31'h0000_0000, ctrl_en_q};
      end else if (AVS_ADDRESS_IN == `HBCP_OFF_STATUS) begin
        rdata_d = {29'h0000_0000, status_q};
      end else if (AVS_ADDRESS_IN == `HBCP_OFF_MASK) begin
        rdata_d = {29'h0000_0000, mask_q};
      end else if (AVS_ADDRESS_IN == `HBCP_OFF_STATE) begin
        rdata_d = {18'h0_0000, halt_q, st_q, chop_q, gate_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
    if (AVS_WRITE_IN && ack_q) begin
      if (AVS_ADDRESS_IN == `HBCP_OFF_CTRL) begin
        ctrl_en_d = AVS_WRITEDATA_IN[0];
      end else if (AVS_ADDRESS_IN == `HBCP_OFF_STATUS) begin
        status_d = status_q & ~AVS_WRITEDATA_IN[2:0];
      end else if (AVS_ADDRESS_IN == `HBCP_OFF_MASK) begin
        mask_d = AVS_WRITEDATA_IN[2:0];
      end
    end
    // Events set after the clear, so a set wins
    if (halt_rise && fsrc_q[0]) status_d[`HBCP_ST_OVC] = 1'b1;
    if (halt_rise && fsrc_q[1]) status_d[`HBCP_ST_SOV] = 1'b1;
    if (st_q == hbcp_pkg::HBCP_CHARGE && trip_ok) status_d[`HBCP_ST_TRIP] = 1'b1;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_en_q <= `HBCP_CTRL_RST;
      mask_q <= 3'h0;
      status_q <= 3'h0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_en_q <= ctrl_en_d;
      mask_q <= mask_d;
      status_q <= status_d;
    end
  end

  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
  assign AVS_READDATA_OUT = rdata_q;
  assign IRQ_OUT = |(status_q & mask_q);

  // Decode of phase pins: 10 forward, 01 reverse, 11 brake, 00 off
  assign drive = ph_a ^ ph_b;
  assign fwd = ph_a;
  assign tick = (div_q == ACW'(OSC_DIV - 1));
  assign restart = (phase_q != {ph_a, ph_b}) |
                   (tick && chop_q == 4'(`HBCP_CHOP_TICKS - 1) && drive);
  assign fault_in = ovc_s | sov_s;
  assign trip_ok = trip_s && dblk_q == 3'h0 && ablk_q == 3'h0;
  assign halt_rise = halt_d & ~halt_q;

  // Chopper, blanking and fault timing
  always_comb begin
    div_d = tick ? '0 : div_q + ACW'(1);
    chop_d = tick ? chop_q + 4'h1 : chop_q;
    phase_d = {ph_a, ph_b};
    dblk_d = dblk_q;
    ablk_d = (ablk_q != 3'h0) ? ablk_q - 3'h1 : 3'h0;
    fblk_d = fblk_q;
    if (tick && dblk_q != 3'h0) dblk_d = dblk_q - 3'h1;
    if (tick && fblk_q != 2'h0) fblk_d = fblk_q - 2'h1;
    if (restart) begin
      dblk_d = blk_sel ? 3'(`HBCP_DBLK_HI) : 3'(`HBCP_DBLK_LO);
      ablk_d = 3'(`HBCP_ABLK_CYC);
      fblk_d = 2'(`HBCP_FBLK_TICKS);
    end
    pend_d = pend_q | (fault_in && fblk_q == 2'h0);
    fsrc_d = pend_q ? fsrc_q : (fblk_q == 2'h0 ? {sov_s, ovc_s} : 2'h0);
    halt_d = halt_q | (pend_q & tick);
    st_d = st_q;
    case (st_q)
      hbcp_pkg::HBCP_IDLE: begin
        if (drive && ctrl_en_q) st_d = hbcp_pkg::HBCP_CHARGE;
      end
      hbcp_pkg::HBCP_CHARGE: begin
        if (trip_ok) st_d = hbcp_pkg::HBCP_FAST;
      end
      hbcp_pkg::HBCP_FAST: begin
        if (tick && chop_d == 4'(`HBCP_MDT_TICKS) && chop_q < 4'(`HBCP_MDT_TICKS))
          st_d = hbcp_pkg::HBCP_SLOW;
      end
      hbcp_pkg::HBCP_SLOW: begin
        st_d = hbcp_pkg::HBCP_SLOW;
      end
      default: begin
        st_d = hbcp_pkg::HBCP_HALT;
      end
    endcase
    if (st_q != hbcp_pkg::HBCP_HALT && st_q != hbcp_pkg::HBCP_IDLE && restart)
      st_d = hbcp_pkg::HBCP_CHARGE;
    if (!drive || !ctrl_en_q) st_d = hbcp_pkg::HBCP_IDLE;
    if (halt_d) st_d = hbcp_pkg::HBCP_HALT;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      div_q <= '0;
      chop_q <= 4'h0;
      phase_q <= 2'h0;
      dblk_q <= 3'h0;
      ablk_q <= 3'h0;
      fblk_q <= 2'h0;
      pend_q <= 1'b0;
      fsrc_q <= 2'h0;
      halt_q <= 1'b0;
      st_q <= hbcp_pkg::HBCP_IDLE;
    end else begin
      div_q <= div_d;
      chop_q <= chop_d;
      phase_q <= phase_d;
      dblk_q <= dblk_d;
      ablk_q <= ablk_d;
      fblk_q <= fblk_d;
      pend_q <= pend_d;
      fsrc_q <= fsrc_d;
      halt_q <= halt_d;
      st_q <= st_d;
    end
  end

  // Gate map {fhs, fls, shs, sls} with one all-off cycle between patterns
  always_comb begin
    target = 4'h0;
    if (ph_a && ph_b && ctrl_en_q) begin
      target = 4'b0101;
    end else if (st_q == hbcp_pkg::HBCP_CHARGE) begin
      target = fwd ? 4'b1001 : 4'b0110;
    end else if (st_q == hbcp_pkg::HBCP_SLOW) begin
      target = 4'b0101;
    end else if (st_q == hbcp_pkg::HBCP_FAST) begin
      target = fwd ? 4'b0110 : 4'b1001;
    end
    if (halt_q) target = 4'h0;
    gate_d = (gate_q != 4'h0 && target != gate_q) ? 4'h0 : target;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      gate_q <= 4'h0;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign {FIRST_HIGH_SIDE_OUT, FIRST_LOW_SIDE_OUT,
          SECOND_HIGH_SIDE_OUT, SECOND_LOW_SIDE_OUT} = gate_q;

  // Checks
  a_leg_one_exclusive: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !(FIRST_HIGH_SIDE_OUT && FIRST_LOW_SIDE_OUT)) else $error("first leg shoot");
  a_leg_two_exclusive: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !(SECOND_HIGH_SIDE_OUT && SECOND_LOW_SIDE_OUT)) else $error("second leg shoot");
  a_halt_gates_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    halt_q |=> gate_q == 4'h0) else $error("gates on after fault");
  a_halt_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    halt_q |=> halt_q) else $error("fault latch released");
  a_fault_blanked: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    fblk_q != 2'h0 && !pend_q |=> !pend_q || $past(fblk_q) == 2'h0)
    else $error("fault taken in blanking");
  a_fault_to_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    $rose(pend_q) |-> ##[1:OSC_DIV] halt_q) else $error("fault not acted on");
  a_blank_length: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    restart |=> dblk_q == ($past(blk_sel) ? 3'(`HBCP_DBLK_HI) : 3'(`HBCP_DBLK_LO)))
    else $error("wrong blanking length");
  a_trip_suppressed: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    st_q == hbcp_pkg::HBCP_CHARGE && (dblk_q != 3'h0 || ablk_q != 3'h0) && !halt_d &&
    !restart && drive && ctrl_en_q |=> st_q == hbcp_pkg::HBCP_CHARGE)
    else $error("trip during blanking");
  a_chop_period: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    tick && chop_q == 4'hF |=> chop_q == 4'h0) else $error("chop period wrong");
  a_late_trip_fast: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    st_q == hbcp_pkg::HBCP_CHARGE && trip_ok && chop_q >= 4'(`HBCP_MDT_TICKS) && !restart
    && !halt_d && drive && ctrl_en_q |=> st_q == hbcp_pkg::HBCP_FAST)
    else $error("late trip not fast");
  a_fwd_charge_map: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    gate_q != 4'h0 && $past(st_q) == hbcp_pkg::HBCP_CHARGE && $past(fwd) &&
    !$past(ph_b) |-> gate_q == 4'b1001) else $error("forward charge map");
  a_rev_charge_map: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    gate_q != 4'h0 && $past(st_q) == hbcp_pkg::HBCP_CHARGE && !$past(fwd) |->
    gate_q == 4'b0110) else $error("reverse charge map");
endmodule

// [hbcp_ctrl_model.sv]
// External controller model driving the phase and blanking-select pins
`timescale 1ns/1ns
module hbcp_ctrl_model (
  // Clock and commands
  input wire logic clk_in,
  input wire logic [1:0] phase_cmd_in,
  input wire logic blank_cmd_in,
  // Pins toward the bridge
  output logic phase_a_out,
  output logic phase_b_out,
  output logic blank_sel_out
);
  // Pins change only just after a clock edge and then hold
  always_ff @(posedge clk_in) begin
    phase_a_out <= phase_cmd_in[1];
    phase_b_out <= phase_cmd_in[0];
    blank_sel_out <= blank_cmd_in;
  end
endmodule

// [hbcp_bridge_tb.sv]
// Self-checking bench of the H-bridge chopper block
`timescale 1ns/1ns
module hbcp_bridge_tb;
  logic clk = 0, rst_n = 0, trip = 0, ovc = 0, sov = 0, rd = 0, wr = 0, blank_cmd = 0;
  logic pa, pb, bsel, wreq, irq, fhs, fls, shs, sls;
  logic [1:0] ph_cmd = 2'b00;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdat, q;
  logic [3:0] exp_t [4] = '{4'b1001, 4'b0110, 4'b0101, 4'b0000};
  logic [1:0] ph_t [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
  int num_errors = 0, comparisons = 0, cyc = 0;
  // Clock
  always #50 clk = ~clk;
  // Edge samples, leg overlap watch and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if ((fhs & fls) === 1'b1 || (shs & sls) === 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: leg shoot-through", $time);
    end
    if (cyc > 20000) begin
      num_errors++;
      conclude();
    end
  end
  hbcp_ctrl_model u_hbcp_ctrl_model (.clk_in(clk), .phase_cmd_in(ph_cmd),
    .blank_cmd_in(blank_cmd), .phase_a_out(pa), .phase_b_out(pb), .blank_sel_out(bsel));
  hbcp_bridge #(.OSC_DIV(2)) u_hbcp_bridge (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .PHASE_A_IN(pa), .PHASE_B_IN(pb), .BLANK_SELECT_BRIDGE_A_IN(bsel), .TRIP_CMP_IN(trip),
    .OVER_CURRENT_FAULT_IN(ovc), .SENSE_OVERVOLTAGE_FAULT_IN(sov), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wreq), .FIRST_HIGH_SIDE_OUT(fhs), .FIRST_LOW_SIDE_OUT(fls),
    .SECOND_HIGH_SIDE_OUT(shs), .SECOND_LOW_SIDE_OUT(sls), .IRQ_OUT(irq));
  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One Avalon-MM access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("unexpected at %0t: bus wait timed out", $time);
    end
  endtask
  // Register word comparison
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  // Gate pattern comparison {fhs,fls,shs,sls}
  task automatic chk_gates(input logic [3:0] exp);
    comparisons++;
    if ({fhs, fls, shs, sls} !== exp) begin
      num_errors++;
      $display("unexpected at %0t: gates %b, wanted %b", $time, {fhs, fls, shs, sls}, exp);
    end
  endtask
  // Bounded wait for a gate pattern, then compare
  task automatic wait_gates(input logic [3:0] exp);
    int n;
    n = 0;
    while ({fhs, fls, shs, sls} !== exp && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk_gates(exp);
  endtask
  // Halt, fault release, persistence across phase change, status
  task automatic fault_run(input logic [31:0] st);
    wait_gates(4'b0000);
    @(posedge clk);
    ovc <= 1'b0;
    sov <= 1'b0;
    ph_cmd <= 2'b01;
    repeat (40) @(posedge clk);
    chk_gates(4'b0000);
    bus(0, 4'h4, 32'h0000_0000);
    chk_word(q, st);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 4'h0, 32'h0000_0000);
    chk_word(q, 32'h0000_0001);
    bus(0, 4'h8, 32'h0000_0000);
    chk_word(q, 32'h0000_0000);
    bus(0, 4'h2, 32'h0000_0000);
    chk_word(q, 32'h0000_0000);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ph_cmd <= ph_t[i];
      blank_cmd <= i[0];
      wait_gates(exp_t[i]);
    end
    $display("test modes done");
    @(posedge clk);
    ph_cmd <= 2'b10;
    repeat (2) @(posedge clk);
    ovc <= 1'b1;
    repeat (3) @(posedge clk);
    ovc <= 1'b0;
    wait_gates(4'b1001);
    repeat (20) @(posedge clk);
    chk_gates(4'b1001);
    $display("test blanking done");
    trip <= 1'b1;
    wait_gates(4'b0110);
    wait_gates(4'b1001);
    wait_gates(4'b0110);
    repeat (8) @(posedge clk);
    chk_gates(4'b0110);
    blank_cmd <= 1'b0;
    wait_gates(4'b0101);
    trip <= 1'b0;
    bus(0, 4'h4, 32'h0000_0000);
    chk_word(q, 32'h0000_0004);
    chk_word({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1, 4'h8, 32'h0000_0004);
    @(posedge clk);
    chk_word({31'h0000_0000, irq}, 32'h0000_0001);
    bus(1, 4'h4, 32'h0000_0004);
    @(posedge clk);
    chk_word({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1, 4'h0, 32'h0000_0000);
    wait_gates(4'b0000);
    bus(1, 4'h0, 32'h0000_0001);
    $display("test trip and interrupt done");
    wait_gates(4'b1001);
    ovc <= 1'b1;
    fault_run(32'h0000_0001);
    rst_n <= 1'b0;
    ph_cmd <= 2'b10;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wait_gates(4'b1001);
    sov <= 1'b1;
    fault_run(32'h0000_0002);
    $display("test faults done");
    conclude();
  end
endmodule
